// ### design/tcp_pkg.sv
package tcp_pkg;
  localparam int unsigned NUM_CH = 8;
  // wishbone word byte addresses
  localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_COUNTER = 8'h04;
  localparam logic [7:0] ADDR_MODULO = 8'h08;
  localparam logic [7:0] ADDR_CH_BASE = 8'h10;
  localparam logic [7:0] ADDR_CH_STRIDE = 8'h08;
  localparam logic [7:0] ADDR_CH_VALUE_OFS = 8'h04;
  // timer_status_control fields
  localparam int unsigned SC_OVF_BIT = 7;
  localparam int unsigned SC_OVIE_BIT = 6;
  localparam int unsigned SC_CAS_BIT = 5;
  localparam int unsigned SC_CLKS_LSB = 3;
  localparam logic [7:0] SC_RESET = 8'h00;
  // channel_status_control fields
  localparam int unsigned CH_FLAG_BIT = 7;
  localparam int unsigned CH_IE_BIT = 6;
  localparam int unsigned CH_MODE_LSB = 4;
  localparam int unsigned CH_ELS_LSB = 2;
  localparam logic [7:0] CH_SC_RESET = 8'h00;
  localparam logic [15:0] MOD_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_FREE_TOP = 16'hFFFF;
  localparam logic [1:0] CLKS_OFF = 2'h0;
  localparam logic [1:0] CLKS_BUS = 2'h1;
  localparam logic [1:0] CLKS_FIXED = 2'h2;
  localparam logic [1:0] CLKS_EXT = 2'h3;
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h0;
  localparam logic [1:0] MODE_COMPARE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;

  typedef struct packed {
    logic [7:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } tcp_wb_req_s;

  typedef struct packed {
    logic [31:0] dat;
    logic ack;
  } tcp_wb_rsp_s;

  typedef struct packed {
    logic [NUM_CH-1:0] out;
    logic [NUM_CH-1:0] oe;
  } tcp_pin_drive_s;
endpackage

// ### design/tcp_timer.sv
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - channel releases pin when edge select or clock select is zero
// - center-align set: active channels run center PWM, timer drives pin
// - center-align clear: each channel mode picks capture, compare, PWM
// - capture: pin is edge input, edge select picks polarity
// - capture pin passes two-flop synchroniser; pulses need one clock
// - compare: pin driven, toggled, cleared or set on match
// - toggle mode starts from the pin's prior level
// - edge PWM high-true: set at counter zero, clear on match
// - edge PWM low-true: set on match
// - center PWM high-true: clear on match up, set on match down
// - overflow flag sets on wrap to zero after modulo, or at modulo turning point when center-aligned; reset clears
// - flag cleared by read while set then write zero; one ignored
// - overflow during clear sequence restarts it, flag stays set
// - overflow interrupt while enable and flag both set
// - center-align bit selects up or up/down counting
// - one to eight channels, each with control and value registers
// - clock select: off, bus, fixed clock, external source
module tcp_timer #(
  parameter int unsigned CH = tcp_pkg::NUM_CH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire tcp_pkg::tcp_wb_req_s wb_req_i,
  output tcp_pkg::tcp_wb_rsp_s wb_rsp_o,
  input wire logic [CH-1:0] channel_pin_i,
  input wire logic fixed_tick_i,
  input wire logic ext_clk_i,
  output tcp_pkg::tcp_pin_drive_s channel_pin_o,
  output logic irq_o
);
  import tcp_pkg::*;

  typedef struct packed {
    logic [7:0] sc;
    logic [15:0] cnt;
    logic [15:0] modv;
    logic down;
    logic ovf_armed;
    logic [CH-1:0][7:0] ch_sc;
    logic [CH-1:0][15:0] ch_val;
    logic [CH-1:0] pin;
    logic [CH-1:0] sync1;
    logic [CH-1:0] sync2;
    logic [CH-1:0] sync3;
    logic [2:0] ext_sync;
    logic ack;
    logic [31:0] rdat;
  } tcp_state_s;

  tcp_state_s state_reg;
  tcp_state_s state_next;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic access;
  logic wr;
  logic rd;
  logic [2:0] ch_idx;
  logic ch_hit;
  logic ch_is_val;
  logic [7:0] ch_rel;
  logic tick;
  logic wrap;
  logic [15:0] top;
  logic cas;
  logic [1:0] clks;
  logic [31:0] rmux;

  assign access = wb_req_i.cyc & wb_req_i.stb & ~state_reg.ack;
  assign wr = access & wb_req_i.we;
  assign rd = access & ~wb_req_i.we;
  assign ch_rel = wb_req_i.adr - ADDR_CH_BASE;
  assign ch_idx = ch_rel[5:3];
  assign ch_is_val = ch_rel[2];
  assign ch_hit = (wb_req_i.adr >= ADDR_CH_BASE) &&
                  (32'(ch_idx) < CH) && (ch_rel[1:0] == 2'h0) &&
                  (ch_rel[7:6] == 2'h0);
  assign cas = state_reg.sc[SC_CAS_BIT];
  assign clks = state_reg.sc[SC_CLKS_LSB +: 2];
  assign top = (state_reg.modv == MOD_RESET) ? CNT_FREE_TOP : state_reg.modv;

  // count tick source; external edge taken from the synchronised copy
  always_comb begin
    unique case (clks)
      CLKS_OFF: tick = 1'b0;
      CLKS_BUS: tick = 1'b1;
      CLKS_FIXED: tick = fixed_tick_i;
      CLKS_EXT: tick = state_reg.ext_sync[1] & ~state_reg.ext_sync[2];
    endcase
  end

  assign wrap = tick & ~cas & (state_reg.cnt == top);

  always_comb begin
    rmux = 32'h0000_0000;
    if (wb_req_i.adr == ADDR_STATUS_CONTROL) begin
      rmux = {24'h00_0000, state_reg.sc};
    end else if (wb_req_i.adr == ADDR_COUNTER) begin
      rmux = {16'h0000, state_reg.cnt};
    end else if (wb_req_i.adr == ADDR_MODULO) begin
      rmux = {16'h0000, state_reg.modv};
    end else if (ch_hit) begin
      rmux = ch_is_val ? {16'h0000, state_reg.ch_val[ch_idx]}
                       : {24'h00_0000, state_reg.ch_sc[ch_idx]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic ovf_event;
    logic cnt_wr;
    logic [1:0] els;
    logic [1:0] mode;
    logic match;
    logic cap_edge;
    logic rise;
    logic fall;
    ovf_event = 1'b0;
    cnt_wr = 1'b0;
    els = 2'h0;
    mode = 2'h0;
    match = 1'b0;
    cap_edge = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    state_next = state_reg;
    state_next.ack = access;
    state_next.rdat = rd ? rmux : 32'h0000_0000;
    state_next.sync1 = channel_pin_i;
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;
    state_next.ext_sync = {state_reg.ext_sync[1:0], ext_clk_i};

    // counter: up with wrap, or up/down when center-aligned
    if (tick) begin
      if (!cas) begin
        state_next.down = 1'b0;
        if (wrap) begin
          state_next.cnt = CNT_RESET;
          ovf_event = 1'b1;
        end else begin
          state_next.cnt = state_reg.cnt + 16'h0001;
        end
      end else if (state_reg.down) begin
        if (state_reg.cnt == CNT_RESET) begin
          state_next.down = 1'b0;
          state_next.cnt = state_reg.cnt + 16'h0001;
        end else begin
          state_next.cnt = state_reg.cnt - 16'h0001;
        end
      end else if (state_reg.cnt == top) begin
        // overflow at the turning point of the up/down sweep
        state_next.down = 1'b1;
        state_next.cnt = state_reg.cnt - 16'h0001;
        ovf_event = 1'b1;
      end else begin
        state_next.cnt = state_reg.cnt + 16'h0001;
      end
    end

    // overflow clear: read while set arms, write zero then clears
    if (rd && wb_req_i.adr == ADDR_STATUS_CONTROL &&
        state_reg.sc[SC_OVF_BIT]) begin
      state_next.ovf_armed = 1'b1;
    end
    if (wr && wb_req_i.adr == ADDR_STATUS_CONTROL && wb_req_i.sel[0]) begin
      state_next.sc[6:0] = wb_req_i.dat[6:0];
      if (!wb_req_i.dat[SC_OVF_BIT] && state_reg.ovf_armed) begin
        state_next.sc[SC_OVF_BIT] = 1'b0;
      end
      state_next.ovf_armed = 1'b0;
    end
    if (ovf_event) begin
      state_next.sc[SC_OVF_BIT] = 1'b1; // set wins over clear
      state_next.ovf_armed = 1'b0;
    end

    if (wr && wb_req_i.adr == ADDR_COUNTER) begin
      cnt_wr = 1'b1;
    end
    if (wr && wb_req_i.adr == ADDR_MODULO) begin
      if (wb_req_i.sel[0]) state_next.modv[7:0] = wb_req_i.dat[7:0];
      if (wb_req_i.sel[1]) state_next.modv[15:8] = wb_req_i.dat[15:8];
    end

    // channel behaviour, one iteration per channel
    for (int i = 0; i < CH; i++) begin
      els = state_reg.ch_sc[i][CH_ELS_LSB +: 2];
      mode = state_reg.ch_sc[i][CH_MODE_LSB +: 2];
      match = tick && (state_reg.cnt == state_reg.ch_val[i]);
      rise = state_reg.sync2[i] & ~state_reg.sync3[i];
      fall = ~state_reg.sync2[i] & state_reg.sync3[i];
      cap_edge = 1'b0;
      // pin level tracks the input while released so toggle starts there
      if (els == ELS_OFF || clks == CLKS_OFF) begin
        state_next.pin[i] = state_reg.sync2[i];
      end else if (cas) begin
        if (match && !state_reg.down) begin
          state_next.pin[i] = els[0];
        end else if (match && state_reg.down) begin
          state_next.pin[i] = ~els[0];
        end
      end else if (mode == MODE_CAPTURE) begin
        cap_edge = (els == ELS_TOGGLE) ? rise :
                   (els == ELS_CLEAR) ? fall : (rise | fall);
        state_next.pin[i] = state_reg.sync2[i];
        if (cap_edge) begin
          state_next.ch_val[i] = state_reg.cnt;
          state_next.ch_sc[i][CH_FLAG_BIT] = 1'b1;
        end
      end else if (mode == MODE_COMPARE) begin
        if (match) begin
          state_next.ch_sc[i][CH_FLAG_BIT] = 1'b1;
          unique case (els)
            ELS_TOGGLE: state_next.pin[i] = ~state_reg.pin[i];
            ELS_CLEAR: state_next.pin[i] = 1'b0;
            default: state_next.pin[i] = 1'b1;
          endcase
        end
      end else begin
        // wrap start wins over a match at the modulo, so a value equal to the modulo keeps the pin active
        if (tick && wrap) begin
          state_next.pin[i] = els[0] ? 1'b0 : 1'b1;
        end else if (match) begin
          state_next.pin[i] = els[0] ? 1'b1 : 1'b0;
          state_next.ch_sc[i][CH_FLAG_BIT] = 1'b1;
        end
      end
      if (cas && match && els != ELS_OFF) begin
        state_next.ch_sc[i][CH_FLAG_BIT] = 1'b1;
      end
      // channel register writes; flag is write-one-to-clear
      if (wr && ch_hit && 32'(ch_idx) == i) begin
        if (ch_is_val) begin
          if (wb_req_i.sel[0]) state_next.ch_val[i][7:0] = wb_req_i.dat[7:0];
          if (wb_req_i.sel[1]) begin
            state_next.ch_val[i][15:8] = wb_req_i.dat[15:8];
          end
        end else if (wb_req_i.sel[0]) begin
          state_next.ch_sc[i][6:0] = wb_req_i.dat[6:0];
          if (wb_req_i.dat[CH_FLAG_BIT] && !cap_edge && !match) begin
            state_next.ch_sc[i][CH_FLAG_BIT] = 1'b0;
          end
        end
      end
    end

    if (cnt_wr) begin
      state_next.cnt = CNT_RESET;
      state_next.down = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
      state_reg.sc <= SC_RESET;
      state_reg.modv <= MOD_RESET;
      state_reg.cnt <= CNT_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign wb_rsp_o.ack = state_reg.ack;
  assign wb_rsp_o.dat = state_reg.rdat;

  always_comb begin
    logic any_ch;
    any_ch = 1'b0;
    for (int i = 0; i < CH; i++) begin
      any_ch = any_ch | (state_reg.ch_sc[i][CH_FLAG_BIT] &
                         state_reg.ch_sc[i][CH_IE_BIT]);
    end
    irq_o = (state_reg.sc[SC_OVF_BIT] & state_reg.sc[SC_OVIE_BIT]) |
            any_ch;
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_pin
      if (g < CH) begin : g_on
        logic [1:0] els_g;
        logic [1:0] mode_g;
        assign els_g = state_reg.ch_sc[g][CH_ELS_LSB +: 2];
        assign mode_g = state_reg.ch_sc[g][CH_MODE_LSB +: 2];
        // capture leaves oe low: pin is an input owned by the timer
        assign channel_pin_o.oe[g] = (els_g != ELS_OFF) &&
          (clks != CLKS_OFF) && (cas || mode_g != MODE_CAPTURE);
        assign channel_pin_o.out[g] = state_reg.pin[g];
      end else begin : g_off
        assign channel_pin_o.oe[g] = 1'b0;
        assign channel_pin_o.out[g] = 1'b0;
      end
    end
  endgenerate
endmodule

// ### testbench/tcp_pin_model.sv
`timescale 1ns/1ps
module tcp_pin_model (
  input wire tcp_pkg::tcp_pin_drive_s drv_i,
  input wire logic [tcp_pkg::NUM_CH-1:0] ext_i,
  output logic [tcp_pkg::NUM_CH-1:0] pin_o
);
  import tcp_pkg::*;
  // timer wins where it drives, outside source holds the rest
  assign pin_o = (drv_i.out & drv_i.oe) | (ext_i & ~drv_i.oe);
endmodule

// ### testbench/tcp_timer_checker.sv
`timescale 1ns/1ps
module tcp_timer_checker #(
  parameter int unsigned CH = tcp_pkg::NUM_CH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire tcp_pkg::tcp_wb_req_s wb_req_i,
  input wire tcp_pkg::tcp_wb_rsp_s wb_rsp_o,
  input wire logic [CH-1:0] channel_pin_i,
  input wire logic fixed_tick_i,
  input wire logic ext_clk_i,
  input wire tcp_pkg::tcp_pin_drive_s channel_pin_o,
  input wire logic irq_o
);
  import tcp_pkg::*;
  logic take;
  logic wtake;
  logic [7:0] sc_q;
  logic chie_q;
  assign take = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  assign wtake = take && wb_req_i.we && wb_req_i.sel[0];
  // shadow of control bits; channel enables only ever set, so loose
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sc_q <= SC_RESET;
      chie_q <= 1'b0;
    end else begin
      if (wtake && wb_req_i.adr == ADDR_STATUS_CONTROL) begin
        sc_q <= wb_req_i.dat[7:0];
      end
      if (wtake && wb_req_i.adr >= ADDR_CH_BASE && wb_req_i.dat[6]) begin
        chie_q <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_take;
    take;
  endsequence
  sequence s_ack_once;
    wb_rsp_o.ack ##1 !wb_rsp_o.ack;
  endsequence
  property p_ack;
    s_take |=> s_ack_once;
  endproperty
  property p_idle_dat;
    !wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0;
  endproperty
  property p_rst;
    $fell(rst_i) |-> channel_pin_o.oe == '0 && !irq_o && !wb_rsp_o.ack;
  endproperty
  property p_unused;
    (channel_pin_o.oe >> CH) == '0 && (channel_pin_o.out >> CH) == '0;
  endproperty
  property p_release;
    sc_q[SC_CLKS_LSB +: 2] == CLKS_OFF |-> channel_pin_o.oe == '0;
  endproperty
  property p_sc_read;
    wb_rsp_o.ack && !wb_req_i.we && wb_req_i.adr == ADDR_STATUS_CONTROL
      |-> wb_rsp_o.dat[6:0] == sc_q[6:0];
  endproperty
  property p_irq_mask;
    !sc_q[SC_OVIE_BIT] && !$past(sc_q[SC_OVIE_BIT]) && !chie_q |-> !irq_o;
  endproperty
  property p_irq_fall;
    $fell(irq_o) |-> $past(wtake) || $past(wtake, 2) || $past(rst_i);
  endproperty
  property p_oe_change;
    $changed(channel_pin_o.oe)
      |-> $past(wtake) || $past(wtake, 2) || $past(rst_i);
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack not a single pulse after request");
  a_idle_dat: assert property (p_idle_dat)
    else $error("read data nonzero without ack");
  a_rst: assert property (p_rst)
    else $error("outputs not quiet after reset");
  a_unused: assert property (p_unused)
    else $error("unused channel drives its pin");
  a_release: assert property (p_release)
    else $error("pin driven with clock select off");
  a_sc_read: assert property (p_sc_read)
    else $error("status control readback differs");
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt with all enables clear");
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt dropped without a write");
  a_oe_change: assert property (p_oe_change)
    else $error("pin direction changed without a write");
endmodule

bind tcp_timer tcp_timer_checker #(.CH(CH)) tcp_timer_checker_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
  .channel_pin_i(channel_pin_i), .fixed_tick_i(fixed_tick_i),
  .ext_clk_i(ext_clk_i), .channel_pin_o(channel_pin_o), .irq_o(irq_o));

// ### testbench/tcp_timer_tb.sv
`timescale 1ns/1ps
module tcp_timer_tb;
  import tcp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  tcp_wb_req_s req = '0;
  tcp_wb_rsp_s rsp;
  tcp_pin_drive_s drv;
  logic [NUM_CH-1:0] ext = '0;
  logic [NUM_CH-1:0] pin;
  logic tick = 1'b0;
  logic irq;
  logic [31:0] q;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc_n = 0;
  int lo[4] = '{0, 18, 8, 1};
  int hi[4] = '{0, 28, 14, 5};
  // external source runs at an eighth of the bus clock
  tcp_timer tcp_timer_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
    .wb_rsp_o(rsp), .channel_pin_i(pin), .fixed_tick_i(tick),
    .ext_clk_i(cyc_n[2]), .channel_pin_o(drv), .irq_o(irq));
  tcp_pin_model tcp_pin_model_i (.drv_i(drv), .ext_i(ext), .pin_o(pin));
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    tick <= ~tick;
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, logic [31:0] d);
    int n;
    n = 0;
    req <= '{adr: a, dat: d, sel: 4'hF, we: w, cyc: 1'b1, stb: 1'b1};
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 40);
    chk(rsp.ack, 1'b1);
    q = rsp.dat;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    wb(a, 1'b0, 32'h0);
    chk(q & m, e);
  endtask
  // a concatenation cannot be indexed, so gather the lines first
  function automatic logic obs(input int c);
    logic [8:0] lines;
    lines = {irq, drv.out};
    return lines[c];
  endfunction
  // index 8 waits on the interrupt line
  task automatic wait_on(input int c, input logic v);
    int n;
    n = 0;
    while (obs(c) !== v && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk(obs(c), v);
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    ext <= '0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  function automatic logic [7:0] ch(input int n, input bit v);
    return ADDR_CH_BASE + 8'(n) * ADDR_CH_STRIDE + (v ? 8'h04 : 8'h00);
  endfunction
  function automatic logic [31:0] scv(logic ie, cas, logic [1:0] ck);
    return {24'h000000, 1'b0, ie, cas, ck, 3'h0};
  endfunction
  function automatic logic [31:0] chv(logic f, ie, logic [1:0] m, e);
    return {24'h000000, f, ie, m, e, 2'h0};
  endfunction
  //////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    do_reset();
    rd(ADDR_STATUS_CONTROL, 32'hFF, 32'(SC_RESET));
    rd(ch(7, 0), 32'hFF, 32'(CH_SC_RESET));
    wr(8'hFC, 32'hFF);
    rd(8'hFC, 32'hFFFFFFFF, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_STATUS_CONTROL, scv(1'b0, 1'b0, 2'(k)));
      wr(ADDR_COUNTER, 32'h0);
      repeat (20) @(posedge clk_i);
      wb(ADDR_COUNTER, 1'b0, 32'h0);
      chk(32'(q >= lo[k] && q <= hi[k]), 32'h1);
    end
  endtask
  task automatic t_ovf();
    do_reset();
    wr(ADDR_MODULO, 32'h63);
    wr(ADDR_STATUS_CONTROL, scv(1'b1, 1'b0, CLKS_BUS));
    wait_on(8, 1'b1);
    rd(ADDR_STATUS_CONTROL, 32'h80, 32'h80);
    wr(ADDR_STATUS_CONTROL, 32'h80 | scv(1'b1, 1'b0, CLKS_BUS));
    rd(ADDR_STATUS_CONTROL, 32'h80, 32'h80);
    wr(ADDR_STATUS_CONTROL, scv(1'b1, 1'b0, CLKS_BUS));
    chk(irq, 1'b0);
    wait_on(8, 1'b1);
    rd(ADDR_STATUS_CONTROL, 32'h80, 32'h80);
    repeat (110) @(posedge clk_i);
    wr(ADDR_STATUS_CONTROL, scv(1'b1, 1'b0, CLKS_BUS));
    rd(ADDR_STATUS_CONTROL, 32'h80, 32'h80);
    wr(ADDR_STATUS_CONTROL, 32'h80 | scv(1'b0, 1'b0, CLKS_BUS));
    chk(irq, 1'b0);
    rd(ADDR_STATUS_CONTROL, 32'h80, 32'h80);
  endtask
  task automatic t_cmp();
    do_reset();
    ext[0] <= 1'b1;
    wr(ADDR_MODULO, 32'h27);
    wr(ch(0, 1), 32'h14);
    wr(ch(0, 0), chv(1'b0, 1'b0, MODE_COMPARE, ELS_TOGGLE));
    chk(drv.oe[0], 1'b0);
    wr(ADDR_STATUS_CONTROL, scv(1'b0, 1'b0, CLKS_BUS));
    chk({drv.oe[0], drv.out[0]}, 2'h3);
    wait_on(0, 1'b0);
    wr(ch(0, 0), chv(1'b0, 1'b0, MODE_COMPARE, ELS_SET));
    wait_on(0, 1'b1);
    wr(ch(0, 0), chv(1'b0, 1'b0, MODE_COMPARE, ELS_CLEAR));
    wait_on(0, 1'b0);
    wr(ch(0, 0), chv(1'b0, 1'b0, MODE_COMPARE, ELS_OFF));
    chk(drv.oe[0], 1'b0);
  endtask
  // settle past the first period, then a window of whole periods
  // pin is registered, so it turns one cycle after the match count
  task automatic t_pwm(logic cas, logic [1:0] m, e, logic [31:0] exp);
    logic [31:0] n_hi;
    do_reset();
    wr(ADDR_MODULO, cas ? 32'h8 : 32'h9);
    wr(ch(1, 1), 32'h3);
    wr(ch(1, 0), chv(1'b0, 1'b0, m, e));
    wr(ADDR_STATUS_CONTROL, scv(1'b0, cas, CLKS_BUS));
    chk(drv.oe, 8'h02);
    repeat (20) @(posedge clk_i);
    n_hi = 32'h0;
    repeat (160) begin
      @(posedge clk_i);
      n_hi = n_hi + drv.out[1];
    end
    chk(n_hi, exp);
  endtask
  task automatic t_cap();
    do_reset();
    wr(ADDR_STATUS_CONTROL, scv(1'b0, 1'b0, CLKS_BUS));
    for (int k = 1; k < 4; k++) begin
      wr(ch(3, 0), chv(1'b1, 1'b1, MODE_CAPTURE, 2'(k)));
      chk(drv.oe[3], 1'b0);
      ext[3] <= 1'b1;
      repeat (8) @(posedge clk_i);
      rd(ch(3, 0), 32'h80, {k[0], 7'h00});
      ext[3] <= 1'b0;
      repeat (8) @(posedge clk_i);
      rd(ch(3, 0), 32'h80, 32'h80);
      chk(irq, 1'b1);
    end
  endtask
  initial begin
    t_regs();
    t_ovf();
    t_cmp();
    t_pwm(1'b0, 2'h2, ELS_CLEAR, 32'h40);
    t_pwm(1'b0, 2'h3, ELS_TOGGLE, 32'h60);
    t_pwm(1'b0, 2'h2, ELS_SET, 32'h60);
    t_pwm(1'b1, MODE_CAPTURE, ELS_CLEAR, 32'h3C);
    t_pwm(1'b1, MODE_COMPARE, ELS_SET, 32'h64);
    t_cap();
    wrap_up();
  end
endmodule
